// [rtl/branch_call_clear_ops_exec.sv]
// execution of branch, call, clear-file, watchdog-clear and complement instructions
// Operation
// RQ1: E4h upper byte branches when overflow set
// RQ2: E0h upper byte branches when zero set
// RQ3: taken target is PC plus two plus 2n
// RQ4: one cycle untaken, two taken with flush
// RQ5: call pushes call address plus four
// RQ6: shadow bit copies accumulator, flags, bank pick
// RQ7: call literal loads PC bits 20:1
// RQ8: two-word call encoding, second cycle idle
// RQ9: call reaches full two megabyte space
// RQ10: clear-file writes zero and sets Z
// RQ11: access bit selects access or banked
// RQ12: extended set indexes addresses up to 5Fh
// RQ13: watchdog clear resets counter, sets status bits
// RQ14: complement inverts register, updates N and Z
// RQ15: destination bit picks accumulator or register
// RQ16: decode, read, process, write across phases
`timescale 1ns/10ps
`default_nettype none
`include "exec_cfg.svh"
module branch_call_clear_ops_exec (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] instr_word,
	input wire logic ext_set_en,
	input wire logic [11:0] index_base,
	input wire logic [7:0] mem_rdata,
	output logic [20:0] pc,
	output logic [20:0] return_stack_head,
	output logic [7:0] accumulator,
	output logic [7:0] flags,
	output logic [3:0] bank_pick_reg,
	output logic [7:0] accumulator_shadow,
	output logic [7:0] flags_shadow,
	output logic [3:0] bank_pick_shadow,
	output logic [11:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	output logic watchdog_clear,
	output logic watchdog_expired_flag,
	output logic sleep_entered_flag,
	output logic [3:0] phase_out
);
	import exec_pkg::*;
	phase_t phase;
	cycle_t cyc;
	cycle_t next_cyc;
	logic [15:0] ir;
	logic [7:0] operand;
	logic [7:0] result;
	logic [7:0] call_lo;
	wire [11:0] data_addr;

	function automatic logic [7:0] op_hi(input logic [15:0] w);
		op_hi = w[15:8];
	endfunction : op_hi

	// file-register opcodes, needed on the fetched word and on the latched one
	function automatic logic file_op(input logic [15:0] w);
		file_op = (w[15:9] == `OP_CLEAR_FILE) || (w[15:10] == `OP_INVERT_FILE);
	endfunction : file_op

	phase_gen u_phase (
		.clk(clk),
		.nrst(nrst),
		.phase(phase)
	);

	// address formed from the fetched word, since the read is launched at the Q1 edge
	addr_resolve u_addr (
		.file_addr(instr_word[7:0]),
		.access_bit(instr_word[8]),
		.bank_pick_reg(bank_pick_reg),
		.ext_set_en(ext_set_en),
		.index_base(index_base),
		.data_addr(data_addr)
	);

	// decode of the latched word; flush and call-second cycles decode nothing
	wire active = (cyc == CYC_NORMAL);
	wire is_bov = active && (op_hi(ir) == `OP_BRANCH_OVERFLOW); // RQ1
	wire is_bz = active && (op_hi(ir) == `OP_BRANCH_ZERO); // RQ2
	wire is_call = active && (ir[15:9] == `OP_CALL_HI); // RQ8
	wire is_clr = active && (ir[15:9] == `OP_CLEAR_FILE); // RQ10
	wire is_com = active && (ir[15:10] == `OP_INVERT_FILE); // RQ14
	wire is_wdt = active && (ir == `OP_WATCHDOG_RESET); // RQ13
	wire taken = (is_bov && flags[`FLAG_OV]) || (is_bz && flags[`FLAG_Z]); // RQ1 RQ2
	wire is_file = active && file_op(ir);
	wire fetch_file = active && file_op(instr_word); // RQ16
	wire [20:0] offset2 = {{12{ir[7]}}, ir[7:0], 1'b0}; // RQ3
	wire [20:0] pc_inc = pc + `PC_STEP;
	wire [20:0] branch_target = pc_inc + offset2; // RQ3
	// second word carries k<19:8>; k spans the whole 2 MB space
	wire second_ok = (instr_word[15:12] == `OP_CALL_SECOND); // RQ8
	wire [19:0] call_k = {instr_word[11:0], call_lo}; // RQ9
	wire [20:0] call_target = {call_k, 1'b0}; // RQ7
	wire [7:0] comp_val = ~operand; // RQ14
	wire [7:0] proc_val = is_clr ? 8'h00 : comp_val; // RQ10
	wire write_acc = is_com && !ir[9]; // RQ15
	wire [7:0] next_flags_file = is_clr ? (flags | 8'h04) :
		{flags[7:5], result[7], flags[3], (result == 8'h00), flags[1:0]}; // RQ14

	assign next_cyc = (phase != PH_Q4) ? cyc :
		taken ? CYC_FLUSH :
		is_call ? CYC_CALL2 : CYC_NORMAL; // RQ4 RQ8
	assign phase_out = phase;

	// Q1 latches the word; flush cycle discards the prefetched one
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ir <= 16'h0000;
			cyc <= CYC_NORMAL;
		end else begin
			if (phase == PH_Q1) begin
				ir <= instr_word; // RQ16
			end
			cyc <= next_cyc;
		end
	end

	// Q2 read operand, Q3 process
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			operand <= 8'h00;
			result <= 8'h00;
			call_lo <= 8'h00;
			mem_addr <= 12'h000;
			mem_re <= 1'b0;
		end else begin
			// ir still holds the previous word at this edge
			mem_re <= (phase == PH_Q1) && fetch_file; // RQ16
			if (phase == PH_Q1) begin
				mem_addr <= data_addr; // RQ11 RQ12
			end
			if (phase == PH_Q2) begin
				operand <= mem_rdata; // RQ16
				call_lo <= ir[7:0]; // RQ8
			end
			if (phase == PH_Q3) begin
				result <= proc_val; // RQ16
			end
		end
	end

	// Q4 write destination and pc; stack and shadows written in Q3
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pc <= `RESET_PC;
			return_stack_head <= `RESET_PC;
			accumulator <= 8'h00;
			flags <= `RESET_FLAGS;
			bank_pick_reg <= 4'h0;
			accumulator_shadow <= 8'h00;
			flags_shadow <= `RESET_FLAGS;
			bank_pick_shadow <= 4'h0;
			mem_wdata <= 8'h00;
			mem_we <= 1'b0;
		end else begin
			mem_we <= 1'b0;
			if (phase == PH_Q3 && is_file && !write_acc) begin
				mem_wdata <= proc_val; // RQ10 RQ15
				mem_we <= 1'b1; // RQ16
			end
			if (phase == PH_Q3 && is_call) begin
				return_stack_head <= pc + `CALL_RETURN_STEP; // RQ5
				if (ir[8]) begin
					accumulator_shadow <= accumulator; // RQ6
					flags_shadow <= flags; // RQ6
					bank_pick_shadow <= bank_pick_reg; // RQ6
				end
			end
			if (phase == PH_Q4) begin
				if (taken) begin
					pc <= branch_target; // RQ3
				end else if (is_call && second_ok) begin
					pc <= call_target; // RQ7
				end else if (cyc == CYC_NORMAL) begin
					// flush and call-second cycles hold pc
					pc <= pc_inc; // RQ4
				end
				if (is_file) begin
					flags <= next_flags_file; // RQ10 RQ14
				end
				if (write_acc) begin
					accumulator <= result; // RQ15
				end
			end
		end
	end

	// watchdog strobe and status bits, one cycle in Q4
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			watchdog_clear <= 1'b0;
			watchdog_expired_flag <= 1'b1;
			sleep_entered_flag <= 1'b1;
		end else begin
			watchdog_clear <= (phase == PH_Q3) && is_wdt; // RQ13
			if (phase == PH_Q3 && is_wdt) begin
				watchdog_expired_flag <= 1'b1; // RQ13
				sleep_entered_flag <= 1'b1; // RQ13
			end
		end
	end

	flush_idle_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && taken) |=> (cyc == CYC_FLUSH)) // RQ4
		else $error("taken branch did not enter flush cycle");
	branch_pc_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && taken) |=> (pc == $past(branch_target))) // RQ3
		else $error("branch target wrong");
	bov_untaken_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_bov && !flags[`FLAG_OV]) |=> (cyc == CYC_NORMAL)) // RQ1
		else $error("untaken overflow branch took a second cycle");
	bz_taken_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_bz && flags[`FLAG_Z]) |=> (cyc == CYC_FLUSH)) // RQ2
		else $error("zero branch not taken");
	call_push_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && is_call) |=> (return_stack_head == $past(pc) + `CALL_RETURN_STEP)) // RQ5
		else $error("return address wrong");
	shadow_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && is_call && !ir[8]) |=> $stable(accumulator_shadow)) // RQ6
		else $error("shadow changed with select clear");
	call_second_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_call) |=> (cyc == CYC_CALL2) ##4 (cyc == CYC_NORMAL)) // RQ8
		else $error("call did not take two cycles");
	clear_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && is_clr) |=> (mem_we && mem_wdata == 8'h00) ##1 flags[`FLAG_Z]) // RQ10
		else $error("clear did not write zero and set Z");
	comp_dest_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && write_acc) |=> (accumulator == ~$past(operand))) // RQ15
		else $error("complement result not in accumulator");
	wdt_strobe_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && is_wdt) |=> (watchdog_clear && watchdog_expired_flag)) // RQ13
		else $error("watchdog clear not signalled");

	// pc movement and call targets
	flush_pc_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && cyc == CYC_FLUSH) |=> $stable(pc)) // RQ4
		else $error("flush cycle moved pc");
	call2_pc_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && cyc == CYC_CALL2) |=> $stable(pc)) // RQ8
		else $error("call second cycle moved pc");
	call_target_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_call && second_ok) |=> (pc[20:1] == $past(call_k))) // RQ7
		else $error("call literal not loaded into pc");
	call_even_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_call && second_ok) |=> (pc[0] == 1'b0)) // RQ9
		else $error("call target not even");
	call_word_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_call && !second_ok) |=> (pc == $past(pc) + `PC_STEP)) // RQ8
		else $error("call without second word did not step pc");
	untaken_step_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_bov && !flags[`FLAG_OV]) |=> (pc == $past(pc) + `PC_STEP)) // RQ1
		else $error("untaken overflow branch did not step pc");
	bz_untaken_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_bz && !flags[`FLAG_Z]) |=> (pc == $past(pc) + `PC_STEP)) // RQ2
		else $error("untaken zero branch did not step pc");
	branch_flags_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && (is_bov || is_bz)) |=> $stable(flags)) // RQ3
		else $error("branch changed the flags");

	// return stack and shadow copies
	stack_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && cyc == CYC_CALL2) |=> $stable(return_stack_head)) // RQ5
		else $error("return address moved in call second cycle");
	shadow_copy_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && is_call && ir[8]) |=> (accumulator_shadow == $past(accumulator) &&
		flags_shadow == $past(flags) && bank_pick_shadow == $past(bank_pick_reg))) // RQ6
		else $error("shadow copies not taken");
	shadow_flags_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && is_call && !ir[8]) |=>
		($stable(flags_shadow) && $stable(bank_pick_shadow))) // RQ6
		else $error("flag or bank shadow changed with select clear");
	call_lo_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q2 && is_call) |=> (call_lo == $past(ir[7:0]))) // RQ8
		else $error("low call literal not kept");

	// clear and complement results
	clear_value_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && is_clr) |=> (result == 8'h00)) // RQ10
		else $error("clear result not zero");
	clear_flags_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_clr) |=> (flags[`FLAG_Z] && flags[7:3] == $past(flags[7:3]) &&
		flags[1:0] == $past(flags[1:0]))) // RQ10
		else $error("clear disturbed other flags");
	invert_value_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && is_com) |=> (result == ~$past(operand))) // RQ14
		else $error("complement result wrong");
	invert_flags_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_com) |=> (flags[`FLAG_N] == $past(result[7]) &&
		flags[`FLAG_Z] == ($past(result) == 8'h00))) // RQ14
		else $error("complement flags wrong");
	file_write_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && is_com && ir[9]) |=> (mem_we && mem_wdata == ~$past(operand))) // RQ15
		else $error("complement not written back to register");
	acc_no_write_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && write_acc) |=> !mem_we) // RQ15
		else $error("accumulator destination wrote memory");
	acc_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4 && is_file && !write_acc) |=> $stable(accumulator)) // RQ15
		else $error("register destination changed accumulator");

	// memory strobes and address forming
	read_strobe_a: assert property (@(posedge clk) disable iff (!nrst)
		mem_re |-> (phase == PH_Q2)) // RQ16
		else $error("read strobe outside read phase");
	write_strobe_a: assert property (@(posedge clk) disable iff (!nrst)
		mem_we |-> (phase == PH_Q4)) // RQ16
		else $error("write strobe outside write phase");
	index_addr_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q1 && fetch_file && ext_set_en && !instr_word[8] &&
		instr_word[7:0] <= `INDEXED_LIMIT) |=>
		(mem_addr == $past(index_base + {4'h0, instr_word[7:0]}))) // RQ12
		else $error("indexed address wrong");
	banked_addr_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q1 && fetch_file && instr_word[8]) |=>
		(mem_addr == {$past(bank_pick_reg), $past(instr_word[7:0])})) // RQ11
		else $error("banked address wrong");
	access_addr_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q1 && fetch_file && !instr_word[8] &&
		!(ext_set_en && instr_word[7:0] <= `INDEXED_LIMIT)) |=>
		(mem_addr == {{4{$past(instr_word[7])}}, $past(instr_word[7:0])})) // RQ11
		else $error("access bank address wrong");

	// watchdog strobe and idle cycles
	wdt_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
		watchdog_clear |=> !watchdog_clear) // RQ13
		else $error("watchdog strobe longer than one cycle");
	wdt_sleep_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && is_wdt) |=> sleep_entered_flag) // RQ13
		else $error("power-down status bit not set");
	flush_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q3 && cyc != CYC_NORMAL) |=> (!mem_we && !watchdog_clear)) // RQ4
		else $error("idle cycle executed its word");
	flush_no_read_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q1 && cyc != CYC_NORMAL) |=> !mem_re) // RQ4
		else $error("idle cycle read memory");
	phase_onehot_a: assert property (@(posedge clk) disable iff (!nrst)
		$onehot(phase)) // RQ16
		else $error("phase not one-hot");
	phase_order_a: assert property (@(posedge clk) disable iff (!nrst)
		(phase == PH_Q4) |=> (phase == PH_Q1)) // RQ16
		else $error("phase did not wrap to the first");
	cyc_onehot_a: assert property (@(posedge clk) disable iff (!nrst)
		$onehot(cyc)) // RQ4
		else $error("cycle kind not one-hot");
endmodule : branch_call_clear_ops_exec
`default_nettype wire

// [shared/exec_cfg.svh]
// constants for the branch, call, clear and complement execution block
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define OP_BRANCH_OVERFLOW 8'hE4
`define OP_BRANCH_ZERO 8'hE0
`define OP_CALL_HI 7'h76
`define OP_CALL_SECOND 4'hF
`define OP_CLEAR_FILE 7'h35
`define OP_INVERT_FILE 6'h07
`define OP_WATCHDOG_RESET 16'h0004
`define CALL_RETURN_STEP 21'h000004
`define PC_STEP 21'h000002
`define INDEXED_LIMIT 8'h5F
`define FLAG_N 4
`define FLAG_OV 3
`define FLAG_Z 2
`define RESET_PC 21'h000000
`define RESET_FLAGS 8'h00
`endif

// [shared/exec_pkg.sv]
// types shared by the execution block and its helpers
package exec_pkg;
	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} phase_t;
	typedef enum logic [2:0] {
		CYC_NORMAL = 3'h1,
		CYC_FLUSH = 3'h2,
		CYC_CALL2 = 3'h4
	} cycle_t;
endpackage : exec_pkg

// [rtl/phase_gen.sv]
// four-phase instruction cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module phase_gen (
	input wire logic clk,
	input wire logic nrst,
	output var exec_pkg::phase_t phase
);
	import exec_pkg::*;
	phase_t next_phase;
	assign next_phase = (phase == PH_Q1) ? PH_Q2 :
		(phase == PH_Q2) ? PH_Q3 :
		(phase == PH_Q3) ? PH_Q4 : PH_Q1;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase <= PH_Q1;
		end else begin
			phase <= next_phase;
		end
	end
endmodule : phase_gen
`default_nettype wire

// [rtl/addr_resolve.sv]
// data address formation: access bank, banked or indexed literal offset
`timescale 1ns/10ps
`default_nettype none
`include "exec_cfg.svh"
module addr_resolve (
	input wire logic [7:0] file_addr,
	input wire logic access_bit,
	input wire logic [3:0] bank_pick_reg,
	input wire logic ext_set_en,
	input wire logic [11:0] index_base,
	output logic [11:0] data_addr
);
	wire indexed;
	wire [11:0] banked;
	wire [11:0] access;
	wire [11:0] idx;
	assign indexed = ext_set_en && !access_bit && (file_addr <= `INDEXED_LIMIT); // RQ12
	assign banked = {bank_pick_reg, file_addr}; // RQ11
	// access bank: low half of bank 0, upper half from special bank
	assign access = file_addr[7] ? {4'hF, file_addr} : {4'h0, file_addr}; // RQ11
	assign idx = index_base + {4'h0, file_addr};
	assign data_addr = indexed ? idx : (access_bit ? banked : access);
endmodule : addr_resolve
`default_nettype wire

// [tb/data_mem_model.sv]
// data memory seen by the execution block, one byte per address
`timescale 1ns/10ps
`default_nettype none
module data_mem_model (
	input wire logic clk,
	input wire logic [11:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_we,
	input wire logic mem_re,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:4095];
	logic [7:0] last = 8'h00;
	// outside a read the bus shows the inverse, so stale data never passes
	assign mem_rdata = mem_re ? mem[mem_addr] : ~last;
	always @(posedge clk) begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
		if (mem_re)
			last <= mem[mem_addr];
	end
endmodule : data_mem_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the branch, call, clear and complement block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic ext_set_en = 1'b0;
	logic [11:0] index_base = 12'h300;
	logic [7:0] mem_rdata, accumulator, flags, accumulator_shadow, flags_shadow, mem_wdata;
	logic [20:0] pc, return_stack_head;
	logic [3:0] bank_pick_reg, bank_pick_shadow, phase_out;
	logic [11:0] mem_addr;
	logic mem_we, mem_re, watchdog_clear, watchdog_expired_flag, sleep_entered_flag;
	int errors = 0;
	int num_checks = 0;
	int wd_pulses = 0;
	always #12.5 clk = ~clk;
	branch_call_clear_ops_exec u_dut (.clk(clk), .nrst(nrst), .instr_word(instr_word),
		.ext_set_en(ext_set_en), .index_base(index_base), .mem_rdata(mem_rdata), .pc(pc),
		.return_stack_head(return_stack_head), .accumulator(accumulator), .flags(flags),
		.bank_pick_reg(bank_pick_reg), .accumulator_shadow(accumulator_shadow),
		.flags_shadow(flags_shadow), .bank_pick_shadow(bank_pick_shadow), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .watchdog_clear(watchdog_clear),
		.watchdog_expired_flag(watchdog_expired_flag), .sleep_entered_flag(sleep_entered_flag),
		.phase_out(phase_out));
	data_mem_model u_mem (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
	always @(posedge clk)
		if (watchdog_clear === 1'b1)
			wd_pulses <= wd_pulses + 1;
	task summarize;
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	// first cycle after release runs a no-op word, so code starts at 2
	task rst;
		@(posedge clk);
		nrst <= 1'b0;
		instr_word <= 16'h0000;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
	endtask : rst
	// w is taken at Q1, w2 stands from Q4 and fills the following cycle
	task issue(input logic [15:0] w, input logic [15:0] w2);
		@(posedge clk iff phase_out === 4'h8);
		instr_word <= w;
		repeat (3) @(posedge clk);
		instr_word <= w2;
		@(posedge clk);
		@(negedge clk);
	endtask : issue
	initial begin
		#100000;
		errors++;
		summarize;
	end
	initial begin
		u_mem.mem[12'h020] = 8'h5A;
		u_mem.mem[12'h021] = 8'h13;
		u_mem.mem[12'h022] = 8'hFF;
		u_mem.mem[12'h0F0] = 8'h77;
		u_mem.mem[12'hFF0] = 8'h77;
		u_mem.mem[12'h310] = 8'h77;
		u_mem.mem[12'h060] = 8'h77;
		u_mem.mem[12'h320] = 8'h00;
		rst;
		issue(16'hE405, 16'h0000);
		chk(pc, 32'h4);
		chk(phase_out, 32'h1);
		issue(16'hE005, 16'h0000);
		chk(pc, 32'h8);
		issue(16'h6A20, 16'h0000);
		chk(u_mem.mem[12'h020], 32'h0);
		chk(flags, 32'h04);
		// flush cycle carries a clear that must not run
		issue(16'hE0FD, 16'h6BF0);
		chk(pc, 32'hA);
		issue(16'h0000, 16'h0000);
		chk(u_mem.mem[12'h0F0], 32'h77);
		chk(pc, 32'hC);
		rst;
		issue(16'h1C21, 16'h0000);
		chk(accumulator, 32'hEC);
		chk(flags, 32'h10);
		chk(u_mem.mem[12'h021], 32'h13);
		issue(16'h1E21, 16'h0000);
		chk(u_mem.mem[12'h021], 32'hEC);
		issue(16'h1E22, 16'h0000);
		chk(u_mem.mem[12'h022], 32'h0);
		chk(flags, 32'h04);
		issue(16'h6BF0, 16'h0000);
		chk(u_mem.mem[12'h0F0], 32'h0);
		issue(16'h6AF0, 16'h0000);
		chk(u_mem.mem[12'hFF0], 32'h0);
		chk(bank_pick_reg, 32'h0);
		@(posedge clk);
		ext_set_en <= 1'b1;
		issue(16'h6A10, 16'h0000);
		chk(u_mem.mem[12'h310], 32'h0);
		issue(16'h6A60, 16'h0000);
		chk(u_mem.mem[12'h060], 32'h0);
		rst;
		issue(16'h1C20, 16'h0000);
		issue(16'hECDE, 16'hFABC);
		chk(pc, 32'h1579BC);
		chk(return_stack_head, 32'hA);
		chk(accumulator_shadow, 32'h0);
		issue(16'hEDFF, 16'hFFFF);
		chk(pc, 32'h1FFFFE);
		chk(return_stack_head, 32'h1579C0);
		chk(accumulator_shadow, 32'hFF);
		chk(flags_shadow, 32'h10);
		chk(bank_pick_shadow, 32'h0);
		issue(16'h0004, 16'h0000);
		issue(16'h0000, 16'h0000);
		chk(wd_pulses, 32'h1);
		chk(watchdog_expired_flag, 32'h1);
		chk(sleep_entered_flag, 32'h1);
		summarize;
	end
endmodule : tb
`default_nettype wire
